/* File: fifo_bus_regs.svh */
// timing counts, field positions and idle values of the fifo bus
`ifndef FIFO_BUS_REGS_SVH
`define FIFO_BUS_REGS_SVH
`define FB_NUM_PORTS      8
`define FB_PORT_BITS      3
`define FB_FIFO_DEPTH     16
`define FB_UPPER_LSB      32
`define FB_UPPER_MSB      63
`define FB_LOWER_MSB      31
`define FB_LANE_IDLE      32'hffff_ffff
`define FB_BE_IDLE        4'hf
`define FB_CLK_PERIOD_NS  25
`endif

/* File: fifo_bus_pkg.sv */
// shared types of the fifo bus ends
package fifo_bus_pkg;
    // bus organisation chosen by one setting
    typedef enum logic [1:0] {
        MODE_FULL   = 2'h0,
        MODE_NARROW = 2'h1,
        MODE_SPLIT  = 2'h3
    } bus_mode_t;
    // receive read beat kinds
    typedef enum logic [1:0] {
        RD_DATA   = 2'h0,
        RD_STATUS = 2'h1
    } rd_state_t;
endpackage

/* File: fifo_bus_if.sv */
// shared fifo bus lines between the bus master and the mac port end
interface fifo_bus_if;
    logic        txsel_n;     // transmit select, low active
    logic        rxsel_n;     // receive select, low active
    logic [2:0]  port_sel;    // port select (rx port in split)
    logic [2:0]  tx_port_sel; // split-mode transmit port select
    logic [63:0] dat_m;       // data driven by master
    logic [63:0] dat_oe_m;    // per-bit master drive enable
    logic [7:0]  be_n_m;      // byte enables from master, low active
    logic        sop_m;
    logic        eop_m;
    logic [63:0] dat_d;       // data driven by device
    logic [63:0] dat_oe_d;    // per-bit device drive enable
    logic [7:0]  be_n_d;
    logic [7:0]  be_oe_d;
    logic        sop_d;
    logic        eop_d;
    logic        fail_d;
    logic        ctl_oe_d;    // enable for sop and eop of device; fail_d is read ungated
    logic [63:0] dat;         // resolved wire values
    logic [7:0]  be_n;
    logic        sop;
    logic        eop;
    // resolve: device wins where enabled, else master; data bits driven by neither are pulled high
    for (genvar i = 0; i < 64; i++) begin : g_res
        assign dat[i] = dat_oe_d[i] ? dat_d[i] : (dat_oe_m[i] ? dat_m[i] : 1'b1);
    end
    for (genvar j = 0; j < 8; j++) begin : g_be
        assign be_n[j] = be_oe_d[j] ? be_n_d[j] : be_n_m[j];
    end
    assign sop = ctl_oe_d ? sop_d : sop_m;
    assign eop = ctl_oe_d ? eop_d : eop_m;
    modport device (input txsel_n, rxsel_n, port_sel, tx_port_sel, dat, be_n, sop, eop,
                    output dat_d, dat_oe_d, be_n_d, be_oe_d, sop_d, eop_d, fail_d, ctl_oe_d);
    modport master (input dat, be_n, sop, eop, fail_d, ctl_oe_d,
                    output txsel_n, rxsel_n, port_sel, tx_port_sel, dat_m, dat_oe_m,
                           be_n_m, sop_m, eop_m);
endinterface

/* File: fifo_bus_device.sv */
// mac side of the fifo bus: per-port transmit and receive fifos
`include "fifo_bus_regs.svh"
module fifo_bus_device
    import fifo_bus_pkg::*;
#(
    parameter int DEPTH = `FB_FIFO_DEPTH
) (
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire bus_mode_t mode,          // bus organisation setting
    fifo_bus_if.device     bus,
    // mac side transmit drain, one port picked by user
    input  wire logic [2:0]  mac_tx_port,
    input  wire logic        mac_tx_ready,
    output logic             mac_tx_valid,
    output logic [63:0]      mac_tx_data,
    output logic [7:0]       mac_tx_be,
    output logic             mac_tx_sop,
    output logic             mac_tx_eop,
    // mac side receive fill
    input  wire logic [2:0]  mac_rx_port,
    input  wire logic        mac_rx_valid,
    input  wire logic [63:0] mac_rx_data,
    input  wire logic [7:0]  mac_rx_be,
    input  wire logic        mac_rx_eop,
    input  wire logic        mac_rx_fail,
    input  wire logic [31:0] mac_rx_status, // status word sent after last word, except in split mode
    output logic             mac_rx_ready
);
    localparam int NP = `FB_NUM_PORTS;
    localparam int AW = $clog2(DEPTH);
    // elaboration check: pointer wrap by the extra msb needs a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_bad
        $error("DEPTH must be a power of two >= 2");
    end
    // entry: data, enables, sop, eop, fail
    localparam int EW = 64 + 8 + 3;

    logic [EW-1:0] tx_mem [NP][DEPTH];  // transmit fifos
    logic [EW-1:0] rx_mem [NP][DEPTH];  // receive fifos
    logic [AW:0]   tx_wp_reg [NP];
    logic [AW:0]   tx_rp_reg [NP];
    logic [AW:0]   rx_wp_reg [NP];
    logic [AW:0]   rx_rp_reg [NP];
    logic [31:0]   rx_stat_reg [NP];     // status pending per port
    rd_state_t     rd_state_reg [NP];
    logic          rx_in_pkt_reg [NP];   // set inside a packet: next pushed word continues it

    // active-low enable into active-high
    function automatic logic [3:0] be_hi(input logic [3:0] be_n);
        return ~be_n;
    endfunction

    // decode of the write side per mode
    logic          tx_take;
    logic [2:0]    tx_port;
    logic [63:0]   tx_word;
    logic [7:0]    tx_be;
    always_comb begin
        tx_take = ~bus.txsel_n;
        tx_port = (mode == MODE_SPLIT) ? bus.tx_port_sel : bus.port_sel;
        tx_word = bus.dat;
        tx_be   = ~bus.be_n;
        if (mode == MODE_NARROW) begin
            tx_word = {32'h0, bus.dat[`FB_LOWER_MSB:0]};
            tx_be   = {4'h0, be_hi(bus.be_n[3:0])};
        end else if (mode == MODE_SPLIT) begin
            tx_word = {32'h0, bus.dat[`FB_UPPER_MSB:`FB_UPPER_LSB]};
            tx_be   = {4'h0, be_hi(bus.be_n[7:4])};
        end
    end
    wire tx_full = (tx_wp_reg[tx_port] ^ {1'b1, {AW{1'b0}}}) == tx_rp_reg[tx_port];
    // a write with no valid byte is dropped; full fifo drops the word too
    wire tx_push = tx_take && !tx_full && (tx_be != 8'h00);

    // transmit write pointers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < NP; p++) tx_wp_reg[p] <= '0;
        end else if (tx_push) begin
            tx_mem[tx_port][tx_wp_reg[tx_port][AW-1:0]] <= {tx_word, tx_be, bus.sop, bus.eop, 1'b0};
            tx_wp_reg[tx_port] <= tx_wp_reg[tx_port] + 1'b1;
        end
    end

    // transmit drain, two-entry skid buffer toward mac
    logic [EW-1:0] sk_reg [2];
    logic [1:0]    sk_cnt_reg;
    wire tx_empty = tx_wp_reg[mac_tx_port] == tx_rp_reg[mac_tx_port];
    wire sk_pop   = mac_tx_valid && mac_tx_ready;
    wire sk_push  = !tx_empty && (sk_cnt_reg < 2'd2);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < NP; p++) tx_rp_reg[p] <= '0;
            sk_cnt_reg <= 2'd0;
            sk_reg[0] <= '0;
            sk_reg[1] <= '0;
        end else begin
            if (sk_push) tx_rp_reg[mac_tx_port] <= tx_rp_reg[mac_tx_port] + 1'b1;
            if (sk_pop) sk_reg[0] <= sk_reg[1];
            if (sk_push) begin
                sk_reg[(sk_cnt_reg - (sk_pop ? 2'd1 : 2'd0)) == 2'd0 ? 0 : 1] <=
                    tx_mem[mac_tx_port][tx_rp_reg[mac_tx_port][AW-1:0]];
            end
            sk_cnt_reg <= sk_cnt_reg + (sk_push ? 2'd1 : 2'd0) - (sk_pop ? 2'd1 : 2'd0);
        end
    end
    // mac drain outputs come from the buffer registers
    assign mac_tx_valid = sk_cnt_reg != 2'd0;
    assign mac_tx_data  = sk_reg[0][EW-1:11];
    assign mac_tx_be    = sk_reg[0][10:3];
    assign mac_tx_sop   = sk_reg[0][2];
    assign mac_tx_eop   = sk_reg[0][1];

    // receive fill from mac; stalls when the target fifo is full
    wire rx_full = (rx_wp_reg[mac_rx_port] ^ {1'b1, {AW{1'b0}}}) == rx_rp_reg[mac_rx_port];
    assign mac_rx_ready = !rx_full;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < NP; p++) begin
                rx_wp_reg[p]     <= '0;
                rx_in_pkt_reg[p] <= 1'b0;
                rx_stat_reg[p]   <= '0;
            end
        end else if (mac_rx_valid && !rx_full) begin
            rx_mem[mac_rx_port][rx_wp_reg[mac_rx_port][AW-1:0]] <=
                {mac_rx_data, mac_rx_be, !rx_in_pkt_reg[mac_rx_port], mac_rx_eop, mac_rx_fail};
            rx_wp_reg[mac_rx_port]     <= rx_wp_reg[mac_rx_port] + 1'b1;
            rx_in_pkt_reg[mac_rx_port] <= !mac_rx_eop;
            if (mac_rx_eop) rx_stat_reg[mac_rx_port] <= mac_rx_status;
        end
    end

    // receive read: port from port_sel in every mode, status beat after last word except in split mode
    wire  [2:0]    rp      = bus.port_sel;
    wire           rd_sel  = ~bus.rxsel_n;
    wire           rx_emp  = rx_wp_reg[rp] == rx_rp_reg[rp];
    wire  [EW-1:0] rx_head = rx_mem[rp][rx_rp_reg[rp][AW-1:0]];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < NP; p++) begin
                rx_rp_reg[p]    <= '0;
                rd_state_reg[p] <= RD_DATA;
            end
        end else if (rd_sel) begin
            case (rd_state_reg[rp])
                RD_DATA: begin
                    if (!rx_emp) begin
                        rx_rp_reg[rp] <= rx_rp_reg[rp] + 1'b1;
                        if (rx_head[1] && mode != MODE_SPLIT) rd_state_reg[rp] <= RD_STATUS;
                    end
                end
                RD_STATUS: rd_state_reg[rp] <= RD_DATA;
                default:   rd_state_reg[rp] <= RD_DATA;
            endcase
        end
    end

    // registered receive bus drive
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.dat_d    <= '0;
            bus.dat_oe_d <= '0;
            bus.be_n_d   <= 8'hff;
            bus.be_oe_d  <= '0;
            bus.sop_d    <= 1'b0;
            bus.eop_d    <= 1'b0;
            bus.fail_d   <= 1'b0;
            bus.ctl_oe_d <= 1'b0;
        end else if (!rd_sel) begin
            bus.dat_oe_d <= '0;
            bus.be_oe_d  <= '0;
            bus.ctl_oe_d <= 1'b0;
        end else begin
            bus.ctl_oe_d <= 1'b1;
            if (rd_state_reg[rp] == RD_STATUS) begin
                bus.dat_d  <= {32'h0, rx_stat_reg[rp]};
                bus.be_n_d <= 8'hf0;
                bus.sop_d  <= 1'b0;
                bus.eop_d  <= 1'b0;
                bus.fail_d <= 1'b0;
            end else begin
                bus.dat_d  <= rx_emp ? 64'h0 : rx_head[EW-1:11];
                bus.be_n_d <= rx_emp ? 8'hff : ~rx_head[10:3];
                bus.sop_d  <= !rx_emp && rx_head[2];
                bus.eop_d  <= !rx_emp && rx_head[1];
                bus.fail_d <= !rx_emp && rx_head[0];
            end
            case (mode)
                MODE_FULL: begin
                    bus.dat_oe_d <= {64{1'b1}};
                    bus.be_oe_d  <= 8'hff;
                end
                default: begin
                    bus.dat_oe_d <= {32'h0, 32'hffff_ffff};
                    bus.be_oe_d  <= 8'h0f;
                end
            endcase
        end
    end
endmodule

/* File: fifo_bus_master.sv */
// bus master end of the fifo bus: writes transmit words, reads receive words
`include "fifo_bus_regs.svh"
module fifo_bus_master
    import fifo_bus_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst,
    input  wire bus_mode_t mode,           // must match the device setting
    fifo_bus_if.master     bus,
    // user write request
    input  wire logic        wr_req,       // one write this cycle
    input  wire logic [2:0]  wr_port,
    input  wire logic [63:0] wr_data,
    input  wire logic [7:0]  wr_be,        // high active, contiguous
    input  wire logic        wr_sop,
    input  wire logic        wr_eop,
    // user read request
    input  wire logic        rd_req,       // hold to keep reading
    input  wire logic [2:0]  rd_port,
    output logic             rd_valid,
    output logic [63:0]      rd_data,
    output logic [7:0]       rd_be,
    output logic             rd_sop,
    output logic             rd_eop,
    output logic             rd_fail
);
    // registered drive of all master lines
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bus.txsel_n     <= 1'b1;
            bus.rxsel_n     <= 1'b1;
            bus.port_sel    <= 3'h0;
            bus.tx_port_sel <= 3'h0;
            bus.dat_m       <= '0;
            bus.dat_oe_m    <= '0;
            bus.be_n_m      <= 8'hff;
            bus.sop_m       <= 1'b0;
            bus.eop_m       <= 1'b0;
        end else begin
            // reads win the shared lanes except in split mode
            bus.rxsel_n  <= !rd_req;
            bus.txsel_n  <= !(wr_req && (mode == MODE_SPLIT || !rd_req));
            bus.port_sel <= (rd_req || mode == MODE_SPLIT) ? rd_port : wr_port;
            bus.tx_port_sel <= wr_port;
            bus.sop_m    <= wr_sop;
            bus.eop_m    <= wr_eop;
            case (mode)
                MODE_SPLIT: begin
                    bus.dat_m    <= {wr_data[31:0], 32'h0};
                    bus.dat_oe_m <= {32'hffff_ffff, 32'h0};
                    bus.be_n_m   <= {~wr_be[3:0], `FB_BE_IDLE};
                end
                MODE_NARROW: begin
                    bus.dat_m    <= {`FB_LANE_IDLE, wr_data[31:0]};
                    bus.dat_oe_m <= rd_req ? 64'h0 : {64{1'b1}};
                    bus.be_n_m   <= {`FB_BE_IDLE, ~wr_be[3:0]};
                end
                default: begin
                    bus.dat_m    <= wr_data;
                    bus.dat_oe_m <= rd_req ? 64'h0 : {64{1'b1}};
                    bus.be_n_m   <= ~wr_be;
                end
            endcase
        end
    end

    // capture of receive beats one cycle after the device drives
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_valid <= 1'b0;
            rd_data  <= '0;
            rd_be    <= '0;
            rd_sop   <= 1'b0;
            rd_eop   <= 1'b0;
            rd_fail  <= 1'b0;
        end else begin
            rd_valid <= bus.ctl_oe_d;
            rd_data  <= (mode == MODE_FULL) ? bus.dat : {32'h0, bus.dat[31:0]};
            rd_be    <= (mode == MODE_FULL) ? ~bus.be_n : {4'h0, ~bus.be_n[3:0]};
            rd_sop   <= bus.sop;
            rd_eop   <= bus.eop;
            rd_fail  <= bus.fail_d;
        end
    end
endmodule

/* File: fifo_bus_asserts.sv */
// concurrent checks on the shared fifo bus lines
module fifo_bus_asserts
    import fifo_bus_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire bus_mode_t   mode,
    input wire logic        txsel_n,
    input wire logic        rxsel_n,
    input wire logic [63:0] dat_oe_d,
    input wire logic [7:0]  be_oe_d,
    input wire logic        ctl_oe_d,
    input wire logic [63:0] dat,
    input wire logic [7:0]  be_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // a read beat taken in one mode
    sequence s_take(bus_mode_t m);
        !rxsel_n && mode == m;
    endsequence
    // the lanes the device drives on the following beat
    sequence s_drive(logic [63:0] dm, logic [7:0] bm);
        dat_oe_d == dm && be_oe_d == bm && ctl_oe_d;
    endsequence
    a_full_drive: assert property (s_take(MODE_FULL) |=> s_drive('1, 8'hff))
        else $error("full mode read lanes wrong");
    a_narrow_drive: assert property (s_take(MODE_NARROW) |=> s_drive(64'hffff_ffff, 8'h0f))
        else $error("narrow mode read lanes wrong");
    a_split_drive: assert property (s_take(MODE_SPLIT) |=> s_drive(64'hffff_ffff, 8'h0f))
        else $error("split mode read lanes wrong");
    // released lanes must be free for the master one beat later
    a_rx_release: assert property (rxsel_n |=> dat_oe_d == '0 && be_oe_d == '0 && !ctl_oe_d)
        else $error("device still drives after deselect");
    // reset itself is the trigger here, so it cannot also disable the check
    a_reset_idle: assert property (disable iff (1'b0) rst |=> dat_oe_d == '0 && txsel_n && rxsel_n)
        else $error("bus not idle after reset");
    a_upper_high: assert property (mode == MODE_NARROW |-> dat[63:32] == 32'hffff_ffff)
        else $error("upper lanes not high in narrow mode");
    a_sel_apart: assert property (mode != MODE_SPLIT |-> txsel_n || rxsel_n)
        else $error("both selects low on shared lanes");
    a_tx_be_some: assert property (!txsel_n && $past(rxsel_n) && mode != MODE_SPLIT |-> be_n != 8'hff)
        else $error("transmit word with no byte enable");
    a_split_be_some: assert property (!txsel_n && mode == MODE_SPLIT |-> be_n[7:4] != 4'hf)
        else $error("split transmit word with no byte enable");
endmodule

/* File: multiport_mac_fifo_bus_port_tb.sv */
// self-checking bench joining master and device ends across the fifo bus
module multiport_mac_fifo_bus_port_tb import fifo_bus_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 8;                 // small fifo so a fill is short
    logic        clk = 0, rst = 1;
    bus_mode_t   mode = MODE_FULL;
    logic        wr_req = 0, wr_sop = 0, wr_eop = 0, rd_req = 0;
    logic        mac_tx_ready = 0, mac_rx_valid = 0, mac_rx_eop = 0, mac_rx_fail = 0;
    logic [2:0]  wr_port = 0, rd_port = 0, mac_tx_port = 0, mac_rx_port = 0, p;
    logic [63:0] wr_data = 0, mac_rx_data = 0;
    logic [7:0]  wr_be = 8'h01, mac_rx_be = 8'h01;
    logic [31:0] mac_rx_status = 0;
    logic        rd_valid, rd_sop, rd_eop, rd_fail, mac_tx_valid, mac_tx_sop, mac_tx_eop;
    logic        mac_rx_ready;
    logic [63:0] rd_data, mac_tx_data;
    logic [7:0]  rd_be, mac_tx_be;
    int          fails = 0, comparisons = 0, cycles = 0;
    logic [74:0] txe_q[$], txm_q[$], rde_q[$], rdm_q[$];   // expected {fail, sop, eop, be, data}, masks
    bus_mode_t   modes[3] = '{MODE_FULL, MODE_NARROW, MODE_SPLIT};
    fifo_bus_if fifo_bus_if_i ();
    fifo_bus_device #(.DEPTH(DEPTH)) fifo_bus_device_i (.clk, .rst, .mode, .bus(fifo_bus_if_i),
        .mac_tx_port, .mac_tx_ready, .mac_tx_valid, .mac_tx_data, .mac_tx_be, .mac_tx_sop,
        .mac_tx_eop, .mac_rx_port, .mac_rx_valid, .mac_rx_data, .mac_rx_be, .mac_rx_eop,
        .mac_rx_fail, .mac_rx_status, .mac_rx_ready);
    fifo_bus_master fifo_bus_master_i (.clk, .rst, .mode, .bus(fifo_bus_if_i), .wr_req, .wr_port,
        .wr_data, .wr_be, .wr_sop, .wr_eop, .rd_req, .rd_port, .rd_valid, .rd_data, .rd_be,
        .rd_sop, .rd_eop, .rd_fail);
    fifo_bus_asserts fifo_bus_asserts_i (.clk, .rst, .mode, .txsel_n(fifo_bus_if_i.txsel_n),
        .rxsel_n(fifo_bus_if_i.rxsel_n), .dat_oe_d(fifo_bus_if_i.dat_oe_d),
        .be_oe_d(fifo_bus_if_i.be_oe_d), .ctl_oe_d(fifo_bus_if_i.ctl_oe_d),
        .dat(fifo_bus_if_i.dat), .be_n(fifo_bus_if_i.be_n));
    // free-running 40 mhz clock
    always #12.5 clk = ~clk;
    // lanes a mode carries: narrow and split move 32 bits and four enables
    function automatic logic [74:0] lanes(bus_mode_t md);
        return (md == MODE_FULL) ? '1 : {3'h7, 8'h0f, 64'hffff_ffff};
    endfunction
    // random contiguous enables, at least one byte
    function automatic logic [7:0] rbe(bus_mode_t md);
        int w, lo, n;
        w = (md == MODE_FULL) ? 8 : 4;
        lo = $urandom_range(w - 1);
        n = $urandom_range(w - lo, 1);
        return 8'(((1 << n) - 1) << lo);
    endfunction
    task automatic chk(string n, logic [74:0] e, logic [74:0] g, logic [74:0] m);
        comparisons++;
        if ((g & m) !== (e & m)) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e & m, g & m);
        end
    endtask
    task automatic end_of_test();
        if (fails == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // watchdog: a hang counts as a mismatch
    always @(posedge clk) begin
        if (++cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end
    // drain and read monitors compare every beat in order
    always @(posedge clk) begin
        if (mac_tx_valid === 1'b1 && mac_tx_ready === 1'b1) begin
            if (txe_q.size() != 0) begin
                chk("mac_tx", txe_q.pop_front(),
                    {1'b0, mac_tx_sop, mac_tx_eop, mac_tx_be, mac_tx_data}, txm_q.pop_front());
            end else begin
                chk("tx_extra", 75'h0, 75'h1, 75'h1);
            end
        end
        if (rd_valid === 1'b1) begin
            if (rde_q.size() != 0) begin
                chk("rd", rde_q.pop_front(),
                    {rd_fail, rd_sop, rd_eop, rd_be, rd_data}, rdm_q.pop_front());
            end else begin
                chk("rd_extra", 75'h0, 75'h1, 75'h1);
            end
        end
    end
    // back-to-back writes; words past keep hit a full fifo and are lost
    task automatic tx_burst(int n, int keep, logic [2:0] pt);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            wr_req = 1'b1;
            wr_port = pt;
            wr_data = {$urandom, $urandom};
            wr_be = rbe(mode);
            wr_sop = (i == 0);
            wr_eop = (i == keep - 1);
            if (i < keep) begin
                txe_q.push_back({1'b0, wr_sop, wr_eop, wr_be, wr_data});
                txm_q.push_back(lanes(mode));
            end
        end
        @(negedge clk);
        wr_req = 1'b0;
    endtask
    // receiver stalls at random while the fifo empties
    task automatic drain();
        int k;
        k = 0;
        while (txe_q.size() != 0 && k < 300) begin
            @(negedge clk);
            mac_tx_ready = 1'($urandom_range(1));
            k++;
        end
        @(negedge clk);
        mac_tx_ready = 1'b0;
        chk("tx_left", 75'h0, 75'(txe_q.size()), '1);
    endtask
    // one packet into a receive fifo, status beat expected after it outside split mode
    task automatic rx_fill(int n, logic [2:0] pt);
        mac_rx_status = $urandom;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            mac_rx_valid = 1'b1;
            mac_rx_port = pt;
            mac_rx_data = {$urandom, $urandom};
            mac_rx_be = rbe(mode);
            mac_rx_eop = (i == n - 1);
            mac_rx_fail = 1'($urandom_range(1));
            rde_q.push_back({mac_rx_fail, 1'(i == 0), mac_rx_eop, mac_rx_be, mac_rx_data});
            rdm_q.push_back(lanes(mode));
        end
        @(negedge clk);
        mac_rx_valid = 1'b0;
        if (mode != MODE_SPLIT) begin
            rde_q.push_back(75'(mac_rx_status));
            rdm_q.push_back({3'h7, 8'h00, 64'hffff_ffff});
        end
    endtask
    // empty fifo read: a beat with every enable off
    task automatic rd_run(int n, logic [2:0] pt, bit empty_tail);
        if (empty_tail) begin
            rde_q.push_back(75'h0);
            rdm_q.push_back(lanes(mode) & {3'h7, 8'hff, 64'h0});
        end
        @(negedge clk);
        rd_port = pt;
        rd_req = 1'b1;
        repeat (n) @(negedge clk);
        rd_req = 1'b0;
        repeat (6) @(negedge clk);
        chk("rd_left", 75'h0, 75'(rde_q.size()), '1);
    endtask
    initial begin
        void'($urandom(32'hc3be));
        foreach (modes[i]) begin
            // a fresh reset per mode also checks a reset in mid-run
            rst = 1'b1;
            mode = modes[i];
            repeat (4) @(negedge clk);
            rst = 1'b0;
            @(negedge clk);
            chk("reset_idle", 75'h1, 75'({rd_valid, mac_tx_valid, mac_rx_ready}), 75'h7);
            p = 3'($urandom);
            mac_tx_port = p ^ 3'h1;
            tx_burst(DEPTH + 1, DEPTH, p);
            repeat (4) @(negedge clk);
            chk("tx_other_port", 73'h0, 73'(mac_tx_valid), 73'h1);
            mac_tx_port = p;
            drain();
            rd_run(1, p ^ 3'h4, 1'b1);
            rx_fill(5, p);
            rd_run(5 + int'(mode != MODE_SPLIT) + 1, p, 1'b1);
        end
        end_of_test();
    end
endmodule
